// >>> design/spi_queue_fault_control.sv
// spi master/slave controller with byte queue, fault and overrun flags
//
// Decided for this implementation: the AHB-Lite interface to the registers.
module spi_queue_fault_control
  import spi_queue_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  input  wire logic        ss_n_in,
  output logic             spi_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        done;
    logic        overrun_flag;
    logic        mode_fault_flag;
    logic        lsb;
    logic        txeie;
    logic        fault_int_enable;
    logic [1:0]  ien;
    logic [7:0]  txb;
    logic        txf;
    logic [7:0]  sh;
    logic [7:0]  rxb;
    logic        busy;
    logic [4:0]  edges;
    logic        sck_o;
    logic        dout;
    logic        mst_oe_n;
    logic        miso_oe_n;
    logic        ss_prev;
    logic        sck_prev;
    logic        seen_done;
    logic        seen_mode_fault_flag;
    logic        ap_rd;
    logic        ap_wr;
    logic [7:0]  ap_idx;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq;
  } state_t;

  state_t      r;
  state_t      next_r;
  logic        tick;
  logic        master;
  logic        en;
  logic        clock_phase;
  logic        clock_polarity;
  logic        slave_select_disable_eff;
  logic        selected;
  logic        din;
  logic        wr_dat;
  logic        edge_hit;
  logic        lead;
  logic        sample;
  logic        start;
  logic        ld;
  logic        done_evt;
  logic        mfault;
  logic [7:0]  sh_nx;
  logic [7:0]  status_v;

  spi_sync_if sy ();

  spi_pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sck_in  (sck_in),
    .ss_n_in (ss_n_in),
    .mosi_in (mosi_in),
    .miso_in (miso_in),
    .sy      (sy.src)
  );

  spi_rate_div u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (r.busy & master & en),
    .code    ({r.ctrl[B_RATE_HI], r.ctrl[1:0]}),
    .tick    (tick)
  );

  function automatic logic outbit(input logic [7:0] v, input logic lsbf);
    return lsbf ? v[0] : v[7];
  endfunction : outbit

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r    = r;
    sh_nx     = r.sh;
    wr_dat    = 1'b0;
    edge_hit  = 1'b0;
    lead      = 1'b0;
    sample    = 1'b0;
    done_evt  = 1'b0;
    master    = r.ctrl[B_MASTER_SELECT];
    en        = r.ctrl[B_SPI_ENABLE];
    clock_phase      = r.ctrl[B_CLOCK_PHASE];
    clock_polarity      = r.ctrl[B_CLOCK_POLARITY];
    // select disable only counts in slave mode when phase is one
    slave_select_disable_eff = r.ctrl[B_SLAVE_SELECT_DISABLE] & (master | clock_phase);
    selected  = !sy.ss_n | slave_select_disable_eff;
    din       = master ? sy.miso : sy.mosi;
    mfault    = en & master & !r.ctrl[B_SLAVE_SELECT_DISABLE] & !sy.ss_n;
    status_v  = {r.done, 1'b0, r.overrun_flag, r.mode_fault_flag, !r.txf, r.lsb, r.txeie, r.fault_int_enable};
    next_r.ss_prev  = sy.ss_n;
    next_r.sck_prev = sy.sck;

    // bus: reads take one wait state so write side effects land first
    next_r.hready = 1'b1;
    next_r.ap_rd  = 1'b0;
    next_r.ap_wr  = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      next_r.ap_idx = haddr[9:2];
      next_r.ap_rd  = !hwrite;
      next_r.ap_wr  = hwrite;
      next_r.hready = hwrite;
    end
    if (r.ap_rd)
    begin
      case (r.ap_idx)
        IDX_CONTROL: next_r.hrdata = {24'h000000, r.ctrl};
        IDX_STATUS:
        begin
          next_r.hrdata    = {24'h000000, status_v};
          next_r.overrun_flag       = 1'b0;
          next_r.seen_done = r.done;
          next_r.seen_mode_fault_flag = r.mode_fault_flag;
        end
        IDX_DATA:
        begin
          next_r.hrdata = {24'h000000, r.rxb};
          if (r.seen_done)
          begin
            next_r.done      = 1'b0;
            next_r.seen_done = 1'b0;
          end
        end
        IDX_INT_EN: next_r.hrdata = {30'h00000000, r.ien};
        default: next_r.hrdata = READ_UNMAPPED;
      endcase
    end
    if (r.ap_wr)
    begin
      case (r.ap_idx)
        IDX_CONTROL:
        begin
          next_r.ctrl = hwdata[7:0];
          if (r.seen_mode_fault_flag)
          begin
            next_r.mode_fault_flag      = 1'b0;
            next_r.seen_mode_fault_flag = 1'b0;
          end
        end
        IDX_STATUS:
        begin
          next_r.lsb    = hwdata[S_LSB];
          next_r.txeie  = hwdata[S_TXEIE];
          next_r.fault_int_enable = hwdata[S_FAULT_INT_ENABLE];
        end
        IDX_DATA:
        begin
          next_r.txb = hwdata[7:0];
          next_r.txf = 1'b1;
          wr_dat     = 1'b1;
          if (r.seen_done)
          begin
            next_r.done      = 1'b0;
            next_r.seen_done = 1'b0;
          end
        end
        IDX_INT_EN: next_r.ien = hwdata[1:0];
        default: ;
      endcase
    end

    // shift engine runs after the bus so hardware sets win over clears
    start = 1'b0;
    if (!en)
    begin
      next_r.busy  = 1'b0;
      next_r.edges = 5'h00;
      next_r.sck_o = 1'b1;
    end
    else if (master)
    begin
      if (mfault)
      begin
        next_r.mode_fault_flag         = 1'b1;
        next_r.ctrl[B_SPI_ENABLE] = 1'b0;
        next_r.ctrl[B_MASTER_SELECT] = 1'b0;
        next_r.busy         = 1'b0;
        next_r.sck_o        = clock_polarity;
      end
      else if (!r.busy)
      begin
        next_r.sck_o = clock_polarity;
        start        = r.txf;
      end
      else if (tick)
      begin
        edge_hit     = 1'b1;
        lead         = !r.edges[0];
        next_r.sck_o = ~r.sck_o;
      end
    end
    else
    begin
      if (!selected)
      begin
        // a half byte is thrown away, the next select starts afresh
        next_r.busy  = 1'b0;
        next_r.edges = 5'h00;
      end
      else if (!r.busy)
        start = 1'b1;
      else if (sy.sck != r.sck_prev)
      begin
        edge_hit = 1'b1;
        lead     = (sy.sck != clock_polarity);
      end
      if (!r.ss_prev && sy.ss_n && !slave_select_disable_eff)
        next_r.mode_fault_flag = 1'b1;
    end

    ld = r.txf & (start | (en & !master & selected & r.busy & (r.edges == 5'h00) & !edge_hit));
    if (ld)
    begin
      sh_nx      = r.txb;
      next_r.txf = wr_dat;
    end
    if (start | ld)
    begin
      next_r.busy  = 1'b1;
      next_r.edges = 5'h00;
      if (!clock_phase)
        next_r.dout = outbit(sh_nx, r.lsb);
    end

    if (edge_hit)
    begin
      next_r.edges = 5'(r.edges + 5'h01);
      sample       = clock_phase ? !lead : lead;
      if (sample)
        sh_nx = r.lsb ? {din, r.sh[7:1]} : {r.sh[6:0], din};
      else
        next_r.dout = outbit(r.sh, r.lsb);
      if (r.edges == LAST_EDGE)
      begin
        done_evt = 1'b1;
        if (r.done)
          next_r.overrun_flag = 1'b1;
        else
        begin
          next_r.rxb  = sh_nx;
          next_r.done = 1'b1;
        end
        next_r.edges = 5'h00;
        if (r.txf)
        begin
          sh_nx      = r.txb;
          next_r.txf = wr_dat;
          if (!clock_phase)
            next_r.dout = outbit(r.txb, r.lsb);
        end
        else if (master)
          next_r.busy = 1'b0;
        // a slave with nothing queued sends back what it got
      end
    end
    next_r.sh = sh_nx;

    // enable follows the same registered mode as sck_o, so no clock glitch on enable
    next_r.mst_oe_n  = !(en & master);
    next_r.miso_oe_n = !(en & !master & selected);
    // done only interrupts while the empty source is off
    next_r.irq = r.ien[E_SPI] & r.ien[E_GLOBAL] &
                 ((r.done & !r.txeie) | (r.mode_fault_flag & r.fault_int_enable) | (!r.txf & r.txeie));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r           <= '0;
      r.ctrl      <= CONTROL_RESET;
      r.lsb       <= STATUS_RESET[S_LSB];
      r.txeie     <= STATUS_RESET[S_TXEIE];
      r.fault_int_enable    <= STATUS_RESET[S_FAULT_INT_ENABLE];
      r.txf       <= !STATUS_RESET[S_TXE];
      r.ien       <= INT_EN_RESET;
      r.sck_o     <= 1'b1;
      r.mst_oe_n  <= 1'b1;
      r.miso_oe_n <= 1'b1;
      r.ss_prev   <= 1'b1;
      r.sck_prev  <= 1'b1;
      r.hready    <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign hreadyout = r.hready;
  assign hrdata    = r.hrdata;
  assign hresp     = r.hresp;
  assign sck_out   = r.sck_o;
  assign sck_oe_n  = r.mst_oe_n;
  assign mosi_out  = r.dout;
  assign mosi_oe_n = r.mst_oe_n;
  assign miso_out  = r.dout;
  assign miso_oe_n = r.miso_oe_n;
  assign spi_irq   = r.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_selected;
    !sy.ss_n && en && !master && !slave_select_disable_eff;
  endsequence
  sequence s_released;
    sy.ss_n && en && !master && !slave_select_disable_eff;
  endsequence

  property p_queue;
    done_evt && r.txf |=> r.busy && r.edges == 5'h00 && r.sh == $past(r.txb);
  endproperty
  a_queue: assert property (p_queue) else $error("queued byte did not follow");

  property p_txe;
    r.ap_wr && r.ap_idx == IDX_DATA |=> r.txf;
  endproperty
  a_txe: assert property (p_txe) else $error("buffer write left empty set");

  property p_master_fault;
    mfault |=> r.mode_fault_flag && !r.ctrl[B_SPI_ENABLE] && !r.ctrl[B_MASTER_SELECT];
  endproperty
  a_master_fault: assert property (p_master_fault) else $error("master fault not taken");

  property p_mode_fault_flag_clear;
    $fell(r.mode_fault_flag) |-> $past(r.ap_wr && r.ap_idx == IDX_CONTROL && r.seen_mode_fault_flag);
  endproperty
  a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear) else $error("fault flag cleared wrongly");

  property p_slave_mode_fault_flag;
    s_selected ##1 s_released |=> r.mode_fault_flag;
  endproperty
  a_slave_mode_fault_flag: assert property (p_slave_mode_fault_flag) else $error("slave fault missed");

  property p_desel;
    en && !master && !selected |=> r.miso_oe_n && !r.busy && r.edges == 5'h00;
  endproperty
  a_desel: assert property (p_desel) else $error("deselected slave still active");

  property p_ovr;
    done_evt && r.done |=> r.overrun_flag && $stable(r.rxb);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun lost unread byte");

  property p_irq;
    r.irq |-> $past(r.ien) == 2'h3;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without both enables");

  property p_status_read;
    r.ap_rd && r.ap_idx == IDX_STATUS |=> r.hready && r.hrdata[7:0] == $past(status_v);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");
endmodule : spi_queue_fault_control

// >>> design/spi_queue_pkg.sv
// shared constants of the spi queue and fault controller
package spi_queue_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_CONTROL    = 8'h91;
  localparam logic [7:0]  IDX_STATUS     = 8'h92;
  localparam logic [7:0]  IDX_DATA       = 8'h93;
  localparam logic [7:0]  IDX_INT_EN     = 8'h94;
  localparam logic [31:0] READ_UNMAPPED  = 32'h00000000;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int          B_RATE_HI      = 7;
  localparam int          B_SPI_ENABLE         = 6;
  localparam int          B_SLAVE_SELECT_DISABLE        = 5;
  localparam int          B_MASTER_SELECT         = 4;
  localparam int          B_CLOCK_POLARITY         = 3;
  localparam int          B_CLOCK_PHASE         = 2;
  localparam logic [7:0]  CONTROL_RESET  = 8'h14;
  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int          S_DONE         = 7;
  localparam int          S_OVR          = 5;
  localparam int          S_MODE_FAULT_FLAG         = 4;
  localparam int          S_TXE          = 3;
  localparam int          S_LSB          = 2;
  localparam int          S_TXEIE        = 1;
  localparam int          S_FAULT_INT_ENABLE       = 0;
  localparam logic [7:0]  STATUS_RESET   = 8'h08;
  // ----------------------------------------------------------------
  // interrupt enable register and transfer timing
  // ----------------------------------------------------------------
  localparam int          E_SPI          = 0;
  localparam int          E_GLOBAL       = 1;
  localparam logic [1:0]  INT_EN_RESET   = 2'h0;
  localparam logic [4:0]  LAST_EDGE      = 5'h0F;
  localparam logic [2:0]  RATE_MAX_CODE  = 3'h6;
endpackage : spi_queue_pkg

// >>> design/spi_sync_if.sv
// synchronised spi pin levels passed from the synchroniser to the core
interface spi_sync_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso;
  modport src (output sck, output ss_n, output mosi, output miso);
  modport dst (input sck, input ss_n, input mosi, input miso);
endinterface : spi_sync_if

// >>> design/spi_pin_sync.sv
// two-stage synchroniser for the spi input pins
module spi_pin_sync
  import spi_queue_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic sck_in,
  input  wire logic ss_n_in,
  input  wire logic mosi_in,
  input  wire logic miso_in,
  spi_sync_if.src   sy
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } sync_t;

  sync_t r;
  sync_t next_r;

  // first stage feeds only the second stage
  always_comb
  begin
    next_r    = r;
    next_r.s1 = {miso_in, mosi_in, ss_n_in, sck_in};
    next_r.s2 = r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '1;
    else
      r <= next_r;
  end

  assign sy.sck  = r.s2[0];
  assign sy.ss_n = r.s2[1];
  assign sy.mosi = r.s2[2];
  assign sy.miso = r.s2[3];
endmodule : spi_pin_sync

// >>> design/spi_rate_div.sv
// half-bit tick generator for master mode
module spi_rate_div
  import spi_queue_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic [2:0] code,
  output logic            tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_t;

  div_t       r;
  div_t       next_r;
  logic [2:0] c;
  logic [6:0] half;

  // a tick every half bit, so a bit lasts 2, 4 .. 128 clocks
  always_comb
  begin
    next_r      = r;
    next_r.tick = 1'b0;
    c           = (code > RATE_MAX_CODE) ? RATE_MAX_CODE : code;
    half        = 7'h01 << c;
    if (!run)
      next_r.cnt = 7'h00;
    else if (r.cnt == 7'(half - 7'h01))
    begin
      next_r.cnt  = 7'h00;
      next_r.tick = 1'b1;
    end
    else
      next_r.cnt = 7'(r.cnt + 7'h01);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick = r.tick;
endmodule : spi_rate_div

// >>> testbench/spi_far_end.sv
// behavioural external spi slave answering the controller in master mode
module spi_far_end
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel,
  output logic            miso,
  output logic [7:0]      last_rx,
  output int              count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx;
  logic [7:0] rx;
  logic       bit_out;
  int         bits;
  initial
  begin
    tx = 8'hC3;
    rx = 8'h00;
    bit_out = 1'b0;
    bits = 0;
    count = 0;
    last_rx = 8'h00;
  end
  // released line shows the inverse of the last bit, never a held value
  assign miso = sel ? bit_out : ~bit_out;
  // phase one, polarity zero: drive on rising, sample on falling
  always @(posedge sck)
    if (sel)
    begin
      bit_out = tx[7];
      tx = {tx[6:0], 1'b0};
    end
  always @(negedge sck)
    if (sel)
    begin
      rx = {rx[6:0], mosi};
      bits = bits + 1;
      if (bits == 8)
      begin
        bits = 0;
        last_rx = rx;
        count = count + 1;
        // each byte differs so a kept byte can be told from a new one
        tx = 8'hC3 + 8'(count);
      end
    end
endmodule : spi_far_end

// >>> testbench/tb_spi_queue_fault_control.sv
// self-checking bench of the spi queue and fault controller
module tb_spi_queue_fault_control;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_queue_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, spi_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_n_in, far_miso;
  logic tb_sck, tb_mosi, far_sel, sck_w, mosi_w, miso_w;
  logic [7:0] far_rx;
  int far_count, mismatches, comparisons, cycles;
  logic [31:0] rd;
  assign hready = hreadyout;
  assign sck_w  = sck_oe_n ? tb_sck : sck_out;
  assign mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
  assign miso_w = miso_oe_n ? far_miso : miso_out;
  spi_queue_fault_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in), .spi_irq(spi_irq));
  spi_far_end far (.sck(sck_w), .mosi(mosi_w), .sel(far_sel), .miso(far_miso), .last_rx(far_rx),
    .count(far_count));
  always #5 hclk = ~hclk;
  // ----------------------------------------------------------------
  // bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0, rd);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (spi_irq !== exp && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, spi_irq}, {31'h0, exp});
  endtask : wait_irq
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(IDX_CONTROL, 32'h00000014);
    rd_chk(IDX_STATUS, 32'h00000008);
    rd_chk(8'hC0, READ_UNMAPPED);
    chk({31'h0, spi_irq}, 32'h0);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_queue;
    int n;
    wr(IDX_CONTROL, 32'h00000057);
    far_sel <= 1'b1;
    wr(IDX_DATA, 32'h000000A5);
    n = 0;
    // next byte queued well before the first ends
    wr(IDX_DATA, 32'h0000003C);
    rd_chk(IDX_STATUS, 32'h00000000);
    while (far_count < 2 && n < 400)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(far_count), 32'd2);
    chk(32'(n <= 260), 32'd1);
    chk({24'h0, far_rx}, 32'h0000003C);
    repeat (8) @(posedge hclk);
    rd_chk(IDX_STATUS, 32'h000000A8);
    rd_chk(IDX_DATA, 32'h000000C3);
    rd_chk(IDX_STATUS, 32'h00000008);
    $display("test queue and overrun done");
  endtask : t_queue
  task automatic t_master_fault;
    wr(IDX_INT_EN, 32'h00000003);
    wr(IDX_STATUS, 32'h00000001);
    wait_irq(1'b0);
    ss_n_in <= 1'b0;
    wait_irq(1'b1);
    ss_n_in <= 1'b1;
    rd_chk(IDX_CONTROL, 32'h00000007);
    wr(IDX_CONTROL, 32'h00000007);
    rd_chk(IDX_STATUS, 32'h00000019);
    wr(IDX_CONTROL, 32'h00000007);
    rd_chk(IDX_STATUS, 32'h00000009);
    wait_irq(1'b0);
    $display("test master fault done");
  endtask : t_master_fault
  task automatic t_select_disable;
    wr(IDX_CONTROL, 32'h00000077);
    ss_n_in <= 1'b0;
    repeat (8) @(posedge hclk);
    rd_chk(IDX_STATUS, 32'h00000009);
    rd_chk(IDX_CONTROL, 32'h00000077);
    $display("test select disable done");
  endtask : t_select_disable
  task automatic t_slave_xfer;
    logic [15:0] mo;
    logic [7:0]  got;
    mo = 16'h5A00;
    got = 8'h00;
    // select stays low from the previous test, phase one allows that
    wr(IDX_CONTROL, 32'h00000044);
    for (int i = 0; i < 16; i++)
    begin
      repeat (6) @(posedge hclk);
      tb_mosi <= mo[15 - i];
      tb_sck <= 1'b1;
      repeat (6) @(posedge hclk);
      got = {got[6:0], miso_w};
      tb_sck <= 1'b0;
      if (i == 7 || i == 15)
      begin
        repeat (8) @(posedge hclk);
        rd_chk(IDX_STATUS, 32'h00000089);
        rd_chk(IDX_DATA, (i == 7) ? 32'h0000005A : 32'h00000000);
      end
    end
    chk({24'h0, got}, 32'h0000005A);
    $display("test slave transfer done");
  endtask : t_slave_xfer
  task automatic t_slave_fault;
    far_sel <= 1'b0;
    wr(IDX_CONTROL, 32'h00000044);
    ss_n_in <= 1'b0;
    repeat (10) @(posedge hclk);
    wait_irq(1'b0);
    chk({31'h0, miso_oe_n}, 32'h0);
    ss_n_in <= 1'b1;
    wait_irq(1'b1);
    chk({31'h0, miso_oe_n}, 32'h1);
    rd_chk(IDX_STATUS, 32'h00000019);
    wr(IDX_INT_EN, 32'h00000001);
    wait_irq(1'b0);
    $display("test slave fault done");
  endtask : t_slave_fault
  // ----------------------------------------------------------------
  // closing report and hang guard
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // whole run needs about six hundred cycles
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      end_sim;
    end
  end
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ss_n_in = 1'b1;
    tb_sck = 1'b0;
    tb_mosi = 1'b1;
    far_sel = 1'b0;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_queue;
    t_master_fault;
    t_select_disable;
    t_slave_xfer;
    t_slave_fault;
    end_sim;
  end
endmodule : tb_spi_queue_fault_control
